// File: hw/blit_pkg.sv
// What this block does
// - A detected button press always switches the backlight on.
// - Backlight goes off after the configured period without button activity.
// - On-time accepts whole seconds from 1 to 65535 as idle timeout.
// - Each count of the setting adds exactly one second of on-time.
// - On-time of zero keeps the backlight lit and never times out.
// - Default on-time is ten seconds.
// - Finished program download loads the default into the on-time word.
// - Backup battery loss restores the default into the on-time word.
package blit_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned TICK_PERIOD_S  = 1;
    localparam int unsigned TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
    localparam logic [25:0] TICK_LAST      = 26'(TICK_CYCLES - 1);

    // Register map, byte addresses
    localparam logic [3:0]  ADDR_ON_TIME   = 4'h0;
    localparam logic [3:0]  ADDR_DEFAULT   = 4'h4;
    localparam logic [3:0]  ADDR_STATUS    = 4'h8;
    localparam logic [3:0]  ADDR_REMAIN    = 4'hc;

    // Field layout and reset values
    localparam int unsigned ON_TIME_W      = 16;
    localparam logic [15:0] ON_TIME_RESET  = 16'h000a;
    localparam int unsigned STAT_LIT_BIT   = 0;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

    typedef enum logic [0:0] {
        BLIT_DARK,
        BLIT_LIT
    } blit_state_type;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } blit_req_type;

endpackage : blit_pkg

// File: hw/blit_tick.sv
`timescale 1ns/10ps
module blit_tick
    import blit_pkg::*;
#(
    parameter logic [25:0] LAST = TICK_LAST
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // Control
    input  wire logic restart,
    output logic      tick
);

    logic [25:0] count;
    wire         wrap = (count == LAST);

    // Restart aligns the first second to the press, not to a free phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count <= 26'h0000000;
            tick  <= 1'b0;
        end else begin
            count <= (restart || wrap) ? 26'h0000000 : count + 26'h0000001;
            tick  <= wrap && !restart;
        end
    end

endmodule : blit_tick

// File: hw/blit_ctrl.sv
`timescale 1ns/10ps
module blit_ctrl
    import blit_pkg::*;
#(
    // Last count of one second; only a bench shortens it
    parameter logic [25:0] TICK_LAST_CYC = TICK_LAST
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Panel side
    input  wire logic        button_press,
    input  wire logic        download_done,
    input  wire logic        battery_lost,
    output logic             backlight_on
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, answer on the second edge

    blit_req_type      req;
    logic              acked;
    logic [15:0]       backlight_on_time;
    logic [15:0]       default_on_time;
    logic [15:0]       remain;
    blit_state_type    state;
    logic              tick;

    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   writedata: avs_writedata, byteenable: avs_byteenable};

    wire        access     = (req.read || req.write) && !acked;
    wire        wr_fire    = access && req.write;
    wire        wr_on_time = wr_fire && (req.address == ADDR_ON_TIME);
    wire        wr_default = wr_fire && (req.address == ADDR_DEFAULT);
    wire [15:0] wr_merge_on = {req.byteenable[1] ? req.writedata[15:8]
                                                 : backlight_on_time[15:8],
                               req.byteenable[0] ? req.writedata[7:0]
                                                 : backlight_on_time[7:0]};
    wire [15:0] wr_merge_df = {req.byteenable[1] ? req.writedata[15:8]
                                                 : default_on_time[15:8],
                               req.byteenable[0] ? req.writedata[7:0]
                                                 : default_on_time[7:0]};
    wire [31:0] rd_mux =
        (req.address == ADDR_ON_TIME) ? {16'h0000, backlight_on_time} :
        (req.address == ADDR_DEFAULT) ? {16'h0000, default_on_time} :
        (req.address == ADDR_STATUS)  ? {31'h00000000, state == BLIT_LIT} :
        (req.address == ADDR_REMAIN)  ? {16'h0000, remain} : UNMAPPED_DATA;

    // waitrequest high at rest, dropped for one cycle to finish a request
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acked           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            acked           <= access;
            avs_waitrequest <= !access;
            avs_readdata    <= access ? rd_mux : avs_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // On-time word and its default

    // Reload events win over a simultaneous software write
    wire load_default = download_done || battery_lost;
    wire [15:0] next_on_time = load_default ? default_on_time :
                               wr_on_time   ? wr_merge_on : backlight_on_time;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            default_on_time   <= ON_TIME_RESET;
            backlight_on_time <= ON_TIME_RESET;
        end else begin
            default_on_time   <= wr_default ? wr_merge_df : default_on_time;
            backlight_on_time <= next_on_time;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Countdown and backlight

    blit_tick #(.LAST(TICK_LAST_CYC)) u_tick (
        .mclk    (mclk),
        .rstn    (rstn),
        .restart (button_press),
        .tick    (tick)
    );

    wire keep_on = (backlight_on_time == 16'h0000);
    wire expire  = tick && (remain == 16'h0001) && !keep_on;

    // Lit at reset: panel powers up showing the display
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state  <= BLIT_LIT;
            remain <= ON_TIME_RESET;
        end else begin
            case (state)
                BLIT_LIT: begin
                    if (button_press) begin
                        remain <= backlight_on_time;
                    end else if (keep_on) begin
                        remain <= 16'h0000;
                    end else if (remain == 16'h0000) begin
                        remain <= backlight_on_time;
                    end else if (expire) begin
                        state  <= BLIT_DARK;
                        remain <= 16'h0000;
                    end else if (tick && remain != 16'h0000) begin
                        remain <= remain - 16'h0001;
                    end
                end
                BLIT_DARK: begin
                    if (button_press || keep_on) begin
                        state  <= BLIT_LIT;
                        remain <= backlight_on_time;
                    end
                end
                default: begin
                    state  <= BLIT_LIT;
                    remain <= backlight_on_time;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            backlight_on <= 1'b1;
        end else begin
            backlight_on <= (state == BLIT_LIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_press;
        button_press;
    endsequence

    sequence s_lit_two;
        ##2 backlight_on;
    endsequence

    a_press_lights_up: assert property (
        @(posedge mclk) disable iff (!rstn) s_press |-> s_lit_two)
        else $error("Backlight not lit after a press");

    a_expire_goes_dark: assert property (
        @(posedge mclk) disable iff (!rstn)
        expire && !button_press && state == BLIT_LIT |-> ##2 !backlight_on)
        else $error("Backlight stayed lit after timeout");

    a_zero_stays_lit: assert property (
        @(posedge mclk) disable iff (!rstn)
        keep_on && !load_default && !wr_on_time [*3] |-> backlight_on)
        else $error("Backlight dark with zero on-time");

    a_press_reloads: assert property (
        @(posedge mclk) disable iff (!rstn)
        button_press |=> remain == $past(backlight_on_time))
        else $error("Countdown not reloaded by press");

    a_tick_decrements: assert property (
        @(posedge mclk) disable iff (!rstn)
        tick && !button_press && state == BLIT_LIT && !keep_on && remain > 16'h0001
        |=> remain == $past(remain) - 16'h0001)
        else $error("Countdown did not drop by one");

    a_download_default: assert property (
        @(posedge mclk) disable iff (!rstn)
        download_done |=> backlight_on_time == $past(default_on_time))
        else $error("Default not loaded after download");

    a_battery_default: assert property (
        @(posedge mclk) disable iff (!rstn)
        battery_lost |=> backlight_on_time == $past(default_on_time))
        else $error("Default not restored after battery loss");

    a_write_takes: assert property (
        @(posedge mclk) disable iff (!rstn)
        wr_on_time && !load_default && req.byteenable[1:0] == 2'h3
        |=> backlight_on_time == $past(req.writedata[15:0]))
        else $error("On-time write lost");

    a_dark_stays_dark: assert property (
        @(posedge mclk) disable iff (!rstn)
        state == BLIT_DARK && !button_press && !keep_on |=> state == BLIT_DARK)
        else $error("Backlight lit without a press");

    ////////////////////////////////////////////////////////////////////////
    // Check helpers: cycles since the last tick or press

    logic [25:0] tick_gap;
    logic        from_press;

    wire        restart_seen  = tick || button_press;
    wire [25:0] next_tick_gap = restart_seen ? 26'h0000000 : tick_gap + 26'h0000001;

    // Reset behaves as a press: the tick counter also restarts from zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tick_gap   <= 26'h0000000;
            from_press <= 1'b1;
        end else begin
            tick_gap   <= next_tick_gap;
            from_press <= button_press ? 1'b1 : (tick ? 1'b0 : from_press);
        end
    end

    sequence s_bus_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_one_wait_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_tick_spacing: assert property (
        @(posedge mclk) disable iff (!rstn)
        tick |-> tick_gap == TICK_LAST_CYC + 26'(from_press))
        else $error("Second tick not one second apart");

    a_tick_not_late: assert property (
        @(posedge mclk) disable iff (!rstn)
        tick_gap <= TICK_LAST_CYC + 26'(from_press))
        else $error("Second tick overdue");

    a_bus_answers: assert property (
        @(posedge mclk) disable iff (!rstn)
        s_bus_take |=> s_one_wait_answer)
        else $error("Bus request not answered after one wait cycle");

    a_bus_rests: assert property (
        @(posedge mclk) disable iff (!rstn)
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("Waitrequest low with no request");

    a_read_on_time: assert property (
        @(posedge mclk) disable iff (!rstn)
        access && req.read && req.address == ADDR_ON_TIME
        |=> avs_readdata == {16'h0000, $past(backlight_on_time)})
        else $error("On-time read returned wrong data");

    a_read_unmapped: assert property (
        @(posedge mclk) disable iff (!rstn)
        access && req.read && req.address[1:0] != 2'h0
        |=> avs_readdata == UNMAPPED_DATA)
        else $error("Unmapped read returned data");

    a_read_remain: assert property (
        @(posedge mclk) disable iff (!rstn)
        access && req.read && req.address == ADDR_REMAIN
        |=> avs_readdata == {16'h0000, $past(remain)})
        else $error("Countdown read returned wrong data");

    a_readdata_holds: assert property (
        @(posedge mclk) disable iff (!rstn)
        !access |=> $stable(avs_readdata))
        else $error("Read data changed with no access");

    a_on_time_holds: assert property (
        @(posedge mclk) disable iff (!rstn)
        !load_default && !wr_on_time |=> $stable(backlight_on_time))
        else $error("On-time word changed with no cause");

    a_default_takes: assert property (
        @(posedge mclk) disable iff (!rstn)
        wr_default && req.byteenable[1:0] == 2'h3
        |=> default_on_time == $past(req.writedata[15:0]))
        else $error("Default on-time write lost");

    a_default_holds: assert property (
        @(posedge mclk) disable iff (!rstn)
        !wr_default |=> $stable(default_on_time))
        else $error("Default on-time changed with no write");

    a_rise_has_cause: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(backlight_on) |-> $past(button_press, 2) || $past(keep_on, 2))
        else $error("Backlight lit with no press");

    a_fall_has_expire: assert property (
        @(posedge mclk) disable iff (!rstn)
        $fell(backlight_on) |-> $past(expire, 2))
        else $error("Backlight dark before timeout");

    a_keep_on_lit: assert property (
        @(posedge mclk) disable iff (!rstn)
        keep_on && state == BLIT_LIT |=> state == BLIT_LIT)
        else $error("Zero on-time let the backlight go dark");

    a_remain_no_rise: assert property (
        @(posedge mclk) disable iff (!rstn)
        state == BLIT_LIT && !button_press && remain != 16'h0000
        |=> remain <= $past(remain))
        else $error("Countdown rose without a press");

    a_zero_count_restarts: assert property (
        @(posedge mclk) disable iff (!rstn)
        state == BLIT_LIT && !keep_on && remain == 16'h0000
        |=> remain == $past(backlight_on_time))
        else $error("Countdown stuck at zero after leaving always-on");

endmodule : blit_ctrl

// File: test/blit_panel.sv
`timescale 1ns/10ps
module blit_panel
    import blit_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // Bench control
    input  wire logic press_req,
    output logic      lit_seen,
    // Panel pins
    output logic      button_press,
    input  wire logic backlight_on
);
    // Buttons pulse one cycle per press, as a debouncer would hand them over
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            button_press <= 1'b0;
            lit_seen     <= 1'b0;
        end else begin
            button_press <= press_req;
            lit_seen     <= backlight_on;
        end
    end
endmodule : blit_panel

// File: test/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import blit_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        button_press;
    logic        download_done = 1'b0;
    logic        battery_lost = 1'b0;
    logic        backlight_on;
    logic        press_req = 1'b0;
    logic        lit_seen;
    logic [31:0] q;
    int          err_total = 0;
    int          checks_done = 0;

    always #12.5 mclk = ~mclk;

    // One second shortened to 1000 cycles so the timeouts fit in the run
    blit_ctrl #(.TICK_LAST_CYC(26'h00003e7)) uut (.mclk(mclk), .rstn(rstn),
        .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .button_press(button_press),
        .download_done(download_done), .battery_lost(battery_lost),
        .backlight_on(backlight_on));
    blit_panel u_panel (.mclk(mclk), .rstn(rstn), .press_req(press_req),
        .lit_seen(lit_seen), .button_press(button_press), .backlight_on(backlight_on));

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low; no fixed latency assumed
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= 4'h3;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // One idle edge, so a following call never lowers and raises in one step
        @(posedge mclk);
    endtask : bus

    task automatic pulse(input int k);
        if (k == 0) press_req <= 1'b1;
        else if (k == 1) download_done <= 1'b1;
        else battery_lost <= 1'b1;
        @(posedge mclk);
        press_req     <= 1'b0;
        download_done <= 1'b0;
        battery_lost  <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        bus(4'h0, 1'b0, 32'h0); chk(q, 32'h0000_000a);
        bus(4'h4, 1'b0, 32'h0); chk(q, 32'h0000_000a);
        bus(4'h0, 1'b1, 32'h0000_ffff);
        bus(4'h0, 1'b0, 32'h0); chk(q, 32'h0000_ffff);
        pulse(0);
        bus(4'hc, 1'b0, 32'h0); chk(q, 32'h0000_ffff);
        bus(4'h8, 1'b0, 32'h0); chk(q, 32'h0000_0001);
        chk({31'h0, lit_seen}, 32'h1);
        bus(4'h0, 1'b1, 32'h1234_0007);
        bus(4'hc, 1'b0, 32'h0); chk(q, 32'h0000_ffff);
        pulse(0);
        bus(4'hc, 1'b0, 32'h0); chk(q, 32'h0000_0007);
        bus(4'h4, 1'b1, 32'h0000_0003);
        pulse(1);
        bus(4'h0, 1'b0, 32'h0); chk(q, 32'h0000_0003);
        bus(4'h0, 1'b1, 32'h0000_0055);
        bus(4'h0, 1'b0, 32'h0); chk(q, 32'h0000_0055);
        pulse(2);
        bus(4'h0, 1'b0, 32'h0); chk(q, 32'h0000_0003);
        bus(4'h0, 1'b1, 32'h0000_0000);
        pulse(0);
        bus(4'h8, 1'b0, 32'h0); chk(q, 32'h0000_0001);
        chk({31'h0, backlight_on}, 32'h1);
        // Unmapped and read-only places answer but keep no data
        bus(4'h8, 1'b1, 32'h0000_0000);
        bus(4'h8, 1'b0, 32'h0); chk(q, 32'h0000_0001);
        bus(4'h1, 1'b1, 32'h0000_00ff);
        bus(4'h1, 1'b0, 32'h0); chk(q, 32'h0000_0000);
        bus(4'h0, 1'b0, 32'h0); chk(q, 32'h0000_0000);
        repeat (2100) @(posedge mclk);
        chk({31'h0, backlight_on}, 32'h1);
        bus(4'h0, 1'b1, 32'h0000_0002);
        pulse(0);
        repeat (1500) @(posedge mclk);
        bus(4'hc, 1'b0, 32'h0); chk(q, 32'h0000_0001);
        repeat (480) @(posedge mclk);
        chk({31'h0, lit_seen}, 32'h1);
        repeat (30) @(posedge mclk);
        chk({31'h0, backlight_on}, 32'h0);
        chk({31'h0, lit_seen}, 32'h0);
        bus(4'h8, 1'b0, 32'h0); chk(q, 32'h0000_0000);
        pulse(0);
        chk({31'h0, backlight_on}, 32'h1);
        print_verdict();
    end

    // Limit well above the longest path through the tests, about 4200 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        print_verdict();
    end
endmodule : tb_top
